// >>> rtl/tei_core.v
// Control-code and escape-sequence interpreter for a 24x80 terminal
`include "tei_regs.vh"

module tei_core (
  input wire core_clk,
  input wire nrst,
  input wire rx_valid,
  input wire [6:0] rx_data,
  output reg rx_ready,
  input wire kb_valid,
  input wire [6:0] kb_data,
  output reg kb_ready,
  input wire alpha_key,
  input wire screen_wipe_key,
  input wire [1:0] mode_sw,
  output reg tx_valid,
  output wire [6:0] tx_data,
  output wire tx_printer,
  input wire tx_ready,
  output reg aux_valid,
  output reg [6:0] aux_data,
  output reg beep,
  output reg kb_enabled,
  output reg protect_mode,
  output reg write_protect,
  output reg alpha_lock,
  output reg [4:0] cursor_row,
  output reg [6:0] cursor_col,
  output reg busy
);

  localparam S_IDLE = 1'b0;
  localparam S_WALK = 1'b1;
  localparam OP_FILL = 4'h0;
  localparam OP_FILLU = 4'h1;
  localparam OP_ELINE = 4'h2;
  localparam OP_EPAGE = 4'h3;
  localparam OP_ROLL = 4'h4;
  localparam OP_SEEK = 4'h5;
  localparam OP_TAB = 4'h6;
  localparam OP_SLINE = 4'h7;
  localparam OP_SPAGE = 4'h8;
  localparam OP_PRINT = 4'h9;

  // Display memory, one protectable bit over each character code
  reg [7:0] mem [0:`TEI_CELL_MAX];
  reg st_reg;
  reg [3:0] op_reg;
  reg [4:0] w_row;
  reg [6:0] w_col;
  reg [10:0] scan_reg;
  reg seen_reg, infield_reg, eol_due_reg, lf_due_reg, fin_reg;
  reg esc_reg;
  reg [1:0] lc_reg;
  reg aux_on_reg, turn_reg, wipe_pend_reg;
  reg push_reg;
  reg [7:0] push_data_reg;
  reg [1:0] cnt_reg, cnt_next;
  reg [7:0] d0_reg, d1_reg;
  reg [1:0] mode_s1, mode_s2;
  reg wipe_s1, wipe_s2, wipe_s3;
  reg mem_we;
  reg [10:0] mem_wa;
  reg [7:0] mem_wd;

  // Linear cell index of a row and column
  function [10:0] tei_lin;
    input [4:0] r;
    input [6:0] c;
    begin
      tei_lin = {r, 6'h00} + {2'h0, r, 4'h0} + {4'h0, c};
    end
  endfunction

  // Walker and cursor geometry
  wire [10:0] w_lin = tei_lin(w_row, w_col);
  wire [10:0] cur_lin = tei_lin(cursor_row, cursor_col);
  wire w_eol = (w_col == `TEI_LAST_COL);
  wire w_bot = (w_row == `TEI_LAST_ROW);
  wire w_end = w_eol && w_bot;
  wire [4:0] w_nrow = w_eol ? (w_bot ? `TEI_ZERO_ROW : w_row + 5'h01) : w_row;
  wire [6:0] w_ncol = w_eol ? `TEI_ZERO_COL : w_col + 7'h01;
  wire [7:0] w_cell = mem[w_lin];
  wire [7:0] b_cell = mem[w_bot ? w_lin : w_lin + `TEI_ROW_STEP];
  wire [7:0] cur_cell = mem[cur_lin];
  wire w_prot = w_cell[`TEI_ATTR_BIT] && protect_mode;
  wire at_saved = (w_row == cursor_row) && (w_col == cursor_col);
  wire cur_bot = (cursor_row == `TEI_LAST_ROW);
  wire [4:0] dn_row = cur_bot ? `TEI_ZERO_ROW : cursor_row + 5'h01;

  // Buffer room counting the word already on its way in
  wire space = (cnt_reg == `TEI_BUF_EMPTY) || ((cnt_reg == `TEI_BUF_ONE) && !push_reg);
  wire pop = tx_valid && tx_ready;

  // Character intake and alpha lock
  wire from_host = rx_valid && rx_ready;
  wire take = from_host || (kb_valid && kb_ready);
  wire [6:0] raw = from_host ? rx_data : kb_data;
  wire is_lc = (raw >= `TEI_LC_A) && (raw <= `TEI_LC_Z);
  wire [6:0] code = (!from_host && alpha_lock && is_lc) ? (raw & `TEI_CASE_MASK) : raw;
  wire kb_on = !from_host && kb_enabled;
  wire kb_send = kb_on && (mode_s2 != `TEI_MODE_BLK);
  wire exec = from_host || (kb_on && (mode_s2 != `TEI_MODE_FDX));
  wire printable = (code >= `TEI_SPACE) && (code != `TEI_DEL);
  wire plain = take && exec && !esc_reg && (lc_reg == `TEI_LC_NONE);
  wire char_wr = plain && printable && !(protect_mode && cur_cell[`TEI_ATTR_BIT]);
  wire [6:0] bias = code - `TEI_ADDR_BIAS;
  wire idle_quiet = (st_reg == S_IDLE) && !take && !wipe_pend_reg && space;

  // Two-flop synchronisers for the mode switch and screen-wipe key pins
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_s1 <= `TEI_MODE_FDX;
      mode_s2 <= `TEI_MODE_FDX;
      wipe_s1 <= 1'b0;
      wipe_s2 <= 1'b0;
      wipe_s3 <= 1'b0;
    end
    else
    begin
      mode_s1 <= mode_sw;
      mode_s2 <= mode_s1;
      wipe_s1 <= screen_wipe_key;
      wipe_s2 <= wipe_s1;
      wipe_s3 <= wipe_s2;
    end
  end

  // Memory write source: walker operations or a stored character
  always @*
  begin
    mem_we = 1'b0;
    mem_wa = w_lin;
    mem_wd = `TEI_NULL_CELL;
    if (st_reg == S_WALK)
    begin
      case (op_reg)
        OP_FILL: mem_we = 1'b1;
        OP_FILLU: mem_we = !w_prot;
        OP_EPAGE: mem_we = !w_prot;
        OP_ELINE: mem_we = !w_prot;
        OP_ROLL:
        begin
          mem_we = 1'b1;
          mem_wd = w_bot ? `TEI_NULL_CELL : b_cell;
        end
        default: mem_we = 1'b0;
      endcase
    end
    else if (char_wr)
    begin
      mem_we = 1'b1;
      mem_wa = cur_lin;
      mem_wd = {write_protect, code};
    end
  end

  always @(posedge core_clk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  // Two-entry transmit buffer
  always @*
  begin
    case ({push_reg, pop})
      2'b10: cnt_next = cnt_reg + 2'h1;
      2'b01: cnt_next = cnt_reg - 2'h1;
      default: cnt_next = cnt_reg;
    endcase
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= `TEI_BUF_EMPTY;
      d0_reg <= `TEI_NULL_CELL;
      d1_reg <= `TEI_NULL_CELL;
      tx_valid <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tx_valid <= (cnt_next != `TEI_BUF_EMPTY);
      if (pop)
        d0_reg <= (push_reg && cnt_reg == `TEI_BUF_ONE) ? push_data_reg : d1_reg;
      else if (push_reg && cnt_reg == `TEI_BUF_EMPTY)
        d0_reg <= push_data_reg;
      if (push_reg && ((pop && cnt_reg == `TEI_BUF_FULL) || (!pop && cnt_reg == `TEI_BUF_ONE)))
        d1_reg <= push_data_reg;
    end
  end

  assign tx_data = d0_reg[6:0];
  assign tx_printer = d0_reg[`TEI_ATTR_BIT];

  // Interpreter and walker sequencer
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= S_IDLE;
      op_reg <= OP_FILL;
      w_row <= `TEI_ZERO_ROW;
      w_col <= `TEI_ZERO_COL;
      scan_reg <= 11'h000;
      seen_reg <= 1'b0;
      infield_reg <= 1'b0;
      eol_due_reg <= 1'b0;
      lf_due_reg <= 1'b0;
      fin_reg <= 1'b0;
      esc_reg <= 1'b0;
      lc_reg <= `TEI_LC_NONE;
      aux_on_reg <= 1'b0;
      turn_reg <= 1'b0;
      wipe_pend_reg <= 1'b0;
      push_reg <= 1'b0;
      push_data_reg <= `TEI_NULL_CELL;
      rx_ready <= 1'b0;
      kb_ready <= 1'b0;
      aux_valid <= 1'b0;
      aux_data <= `TEI_NUL;
      beep <= 1'b0;
      kb_enabled <= 1'b1;
      protect_mode <= 1'b0;
      write_protect <= 1'b0;
      alpha_lock <= 1'b0;
      cursor_row <= `TEI_ZERO_ROW;
      cursor_col <= `TEI_ZERO_COL;
      busy <= 1'b0;
    end
    else
    begin
      turn_reg <= !turn_reg;
      rx_ready <= idle_quiet && turn_reg;
      kb_ready <= idle_quiet && !turn_reg;
      busy <= !idle_quiet;
      push_reg <= 1'b0;
      beep <= 1'b0;
      aux_valid <= 1'b0;
      if (alpha_key)
        alpha_lock <= !alpha_lock;
      if (st_reg == S_IDLE && wipe_pend_reg && !take) // A taken character goes first
      begin
        wipe_pend_reg <= 1'b0;
        kb_enabled <= 1'b1;
        cursor_row <= `TEI_ZERO_ROW;
        cursor_col <= `TEI_ZERO_COL;
        w_row <= `TEI_ZERO_ROW;
        w_col <= `TEI_ZERO_COL;
        op_reg <= OP_FILL;
        st_reg <= S_WALK;
      end
      else if (st_reg == S_IDLE && take)
      begin
        if (kb_send)
        begin
          push_reg <= 1'b1;
          push_data_reg <= {1'b0, code};
        end
        if (from_host && aux_on_reg)
        begin
          aux_valid <= 1'b1;
          aux_data <= code;
        end
        if (exec && lc_reg == `TEI_LC_ROW)
        begin
          cursor_row <= (bias > {2'h0, `TEI_LAST_ROW}) ? `TEI_LAST_ROW : bias[4:0];
          lc_reg <= `TEI_LC_COL;
        end
        else if (exec && lc_reg == `TEI_LC_COL)
        begin
          cursor_col <= (bias > `TEI_LAST_COL) ? `TEI_LAST_COL : bias;
          lc_reg <= `TEI_LC_NONE;
        end
        else if (exec && esc_reg)
        begin
          esc_reg <= 1'b0;
          w_row <= `TEI_ZERO_ROW;
          w_col <= `TEI_ZERO_COL;
          eol_due_reg <= 1'b0;
          lf_due_reg <= 1'b0;
          fin_reg <= 1'b0;
          infield_reg <= 1'b0;
          case (code)
            `TEI_E_AMP:
            begin
              protect_mode <= 1'b1;
              cursor_row <= `TEI_ZERO_ROW;
              cursor_col <= `TEI_ZERO_COL;
              scan_reg <= 11'h000;
              op_reg <= OP_SEEK;
              st_reg <= S_WALK;
            end
            `TEI_E_APOS: protect_mode <= 1'b0;
            `TEI_E_RPAR: write_protect <= 1'b1;
            `TEI_E_LPAR: write_protect <= 1'b0;
            `TEI_E_LOAD: lc_reg <= `TEI_LC_ROW;
            `TEI_E_HASH: kb_enabled <= 1'b0;
            `TEI_E_QUOTE: kb_enabled <= 1'b1;
            `TEI_E_STAR:
            begin
              protect_mode <= 1'b0;
              op_reg <= OP_FILL;
              st_reg <= S_WALK;
            end
            `TEI_E_PLUS:
            begin
              op_reg <= protect_mode ? OP_FILLU : OP_FILL;
              st_reg <= S_WALK;
            end
            `TEI_E_ELINE, `TEI_E_EPAGE:
            begin
              w_row <= cursor_row;
              w_col <= cursor_col;
              op_reg <= (code == `TEI_E_ELINE) ? OP_ELINE : OP_EPAGE;
              st_reg <= S_WALK;
            end
            `TEI_E_LINE:
            begin
              w_row <= cursor_row;
              op_reg <= OP_SLINE;
              st_reg <= S_WALK;
            end
            `TEI_E_PAGE:
            begin
              op_reg <= OP_SPAGE;
              st_reg <= S_WALK;
            end
            `TEI_E_PRINT:
            begin
              eol_due_reg <= 1'b1;
              op_reg <= OP_PRINT;
              st_reg <= S_WALK;
            end
            `TEI_E_AUXON: aux_on_reg <= 1'b1;
            `TEI_E_AUXOFF: aux_on_reg <= 1'b0;
            default: esc_reg <= 1'b0;
          endcase
        end
        else if (exec)
        begin
          scan_reg <= 11'h000;
          case (code)
            `TEI_ESC: esc_reg <= 1'b1;
            `TEI_BEL: beep <= 1'b1;
            `TEI_LF, `TEI_US:
            begin
              if (code == `TEI_US)
                cursor_col <= `TEI_ZERO_COL;
              w_row <= `TEI_ZERO_ROW;
              w_col <= `TEI_ZERO_COL;
              if (cur_bot && !protect_mode)
              begin
                op_reg <= OP_ROLL;
                st_reg <= S_WALK;
              end
              else
              begin
                cursor_row <= dn_row;
                w_row <= dn_row;
                w_col <= (code == `TEI_US) ? `TEI_ZERO_COL : cursor_col;
                op_reg <= OP_SEEK;
                st_reg <= protect_mode ? S_WALK : S_IDLE;
              end
            end
            `TEI_TAB:
            begin
              w_row <= cursor_row;
              w_col <= cursor_col;
              seen_reg <= 1'b0;
              op_reg <= OP_TAB;
              st_reg <= protect_mode ? S_WALK : S_IDLE;
            end
            default:
            begin
              if (printable)
              begin
                cursor_col <= (cursor_col == `TEI_LAST_COL) ? `TEI_ZERO_COL : cursor_col + 7'h01;
                if (cursor_col == `TEI_LAST_COL)
                  cursor_row <= dn_row;
              end
            end
          endcase
        end
      end
      else if (st_reg == S_WALK)
      begin
        case (op_reg)
          OP_FILL, OP_FILLU, OP_EPAGE, OP_ROLL:
          begin
            w_row <= w_nrow;
            w_col <= w_ncol;
            if (w_end)
              st_reg <= S_IDLE;
          end
          OP_ELINE:
          begin
            w_col <= w_ncol;
            if (w_prot || w_eol)
              st_reg <= S_IDLE;
          end
          OP_SEEK:
          begin
            scan_reg <= scan_reg + 11'h001;
            if (!w_prot || scan_reg == `TEI_CELL_MAX)
            begin
              cursor_row <= w_row;
              cursor_col <= w_col;
              st_reg <= S_IDLE;
            end
            else
            begin
              w_row <= w_nrow;
              w_col <= w_ncol;
            end
          end
          OP_TAB:
          begin
            if (w_prot)
              seen_reg <= 1'b1;
            if (!w_prot && seen_reg)
            begin
              cursor_row <= w_row;
              cursor_col <= w_col;
              st_reg <= S_IDLE;
            end
            else if (w_end)
            begin
              cursor_row <= `TEI_ZERO_ROW;
              cursor_col <= `TEI_ZERO_COL;
              w_row <= `TEI_ZERO_ROW;
              w_col <= `TEI_ZERO_COL;
              scan_reg <= 11'h000;
              op_reg <= OP_SEEK;
            end
            else
            begin
              w_row <= w_nrow;
              w_col <= w_ncol;
            end
          end
          default:
          begin
            if (space)
            begin
              push_data_reg[`TEI_ATTR_BIT] <= (op_reg == OP_PRINT);
              if (lf_due_reg)
              begin
                lf_due_reg <= 1'b0;
                push_reg <= 1'b1;
                push_data_reg[6:0] <= `TEI_LF;
                if (fin_reg)
                  st_reg <= S_IDLE;
              end
              else if (eol_due_reg)
              begin
                eol_due_reg <= 1'b0;
                push_reg <= 1'b1;
                push_data_reg[6:0] <= (op_reg == OP_PRINT) ? `TEI_CR : `TEI_US;
                lf_due_reg <= (op_reg == OP_PRINT);
              end
              else if (at_saved)
              begin
                push_reg <= 1'b1;
                push_data_reg[6:0] <= `TEI_CR;
                lf_due_reg <= (op_reg == OP_PRINT);
                fin_reg <= 1'b1;
                if (op_reg != OP_PRINT)
                  st_reg <= S_IDLE;
              end
              else
              begin
                if (w_prot && op_reg == OP_SLINE)
                begin
                  push_reg <= 1'b1;
                  push_data_reg[6:0] <= `TEI_CR;
                  st_reg <= S_IDLE;
                end
                else if (w_prot && op_reg == OP_SPAGE)
                begin
                  infield_reg <= 1'b1;
                  push_reg <= !infield_reg;
                  push_data_reg[6:0] <= `TEI_FS;
                end
                else
                begin
                  infield_reg <= 1'b0;
                  push_reg <= (w_cell[6:0] != `TEI_NUL);
                  push_data_reg[6:0] <= w_cell[6:0];
                end
                w_row <= w_nrow;
                w_col <= w_ncol;
                if (w_eol && op_reg != OP_SLINE)
                  eol_due_reg <= 1'b1;
              end
            end
          end
        endcase
      end
      if (wipe_s2 && !wipe_s3)
        wipe_pend_reg <= 1'b1;
    end
  end

endmodule // tei_core

// >>> rtl/tei_regs.vh
// Constants for the terminal escape-sequence interpreter
`ifndef TEI_REGS_VH
`define TEI_REGS_VH
// Screen geometry: 24 rows of 80 cells
`define TEI_LAST_ROW 5'h17
`define TEI_LAST_COL 7'h4F
`define TEI_CELL_MAX 11'h77F
`define TEI_ROW_STEP 11'h050
`define TEI_ZERO_ROW 5'h00
`define TEI_ZERO_COL 7'h00
// Cell layout: bit 7 protectable, bits 6:0 character code
`define TEI_ATTR_BIT 7
`define TEI_NULL_CELL 8'h00
// Control codes
`define TEI_NUL 7'h00
`define TEI_BEL 7'h07
`define TEI_TAB 7'h09
`define TEI_LF 7'h0A
`define TEI_CR 7'h0D
`define TEI_ESC 7'h1B
`define TEI_FS 7'h1C
`define TEI_US 7'h1F
`define TEI_SPACE 7'h20
`define TEI_DEL 7'h7F
// Second codes of escape sequences
`define TEI_E_QUOTE 7'h22
`define TEI_E_HASH 7'h23
`define TEI_E_AMP 7'h26
`define TEI_E_APOS 7'h27
`define TEI_E_LPAR 7'h28
`define TEI_E_RPAR 7'h29
`define TEI_E_STAR 7'h2A
`define TEI_E_PLUS 7'h2B
`define TEI_E_LINE 7'h34
`define TEI_E_PAGE 7'h35
`define TEI_E_LOAD 7'h3D
`define TEI_E_AUXON 7'h40
`define TEI_E_AUXOFF 7'h41
`define TEI_E_PRINT 7'h50
`define TEI_E_ELINE 7'h54
`define TEI_E_EPAGE 7'h59
// Cursor address bias and upper-case lock
`define TEI_ADDR_BIAS 7'h20
`define TEI_LC_A 7'h61
`define TEI_LC_Z 7'h7A
`define TEI_CASE_MASK 7'h5F
// Duplex switch settings
`define TEI_MODE_FDX 2'h0
`define TEI_MODE_HDX 2'h1
`define TEI_MODE_BLK 2'h2
// Load-cursor phases and buffer fill
`define TEI_LC_NONE 2'h0
`define TEI_LC_ROW 2'h1
`define TEI_LC_COL 2'h2
`define TEI_BUF_EMPTY 2'h0
`define TEI_BUF_ONE 2'h1
`define TEI_BUF_FULL 2'h2
`endif

// >>> testbench/tei_core_sva.sv
// Port assertions for the escape-sequence interpreter
module tei_core_sva (
  input logic core_clk,
  input logic nrst,
  input logic rx_valid,
  input logic [6:0] rx_data,
  input logic rx_ready,
  input logic kb_valid,
  input logic [6:0] kb_data,
  input logic kb_ready,
  input logic alpha_key,
  input logic aux_valid,
  input logic [6:0] aux_data,
  input logic beep,
  input logic kb_enabled,
  input logic protect_mode,
  input logic write_protect,
  input logic alpha_lock,
  input logic [4:0] cursor_row,
  input logic [6:0] cursor_col
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tk;
  logic [6:0] tc;
  // Character taken this cycle from either source, and its code
  assign tk = (rx_valid && rx_ready) || (kb_valid && kb_ready);
  assign tc = rx_ready ? rx_data : kb_data;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_beep_pulse: assert property (beep |=> !beep)
    else $error("beep longer than one cycle");
  a_beep_cause: assert property (beep |-> $past(tk && tc == 7'h07))
    else $error("beep without bell code");
  a_cursor_range: assert property (cursor_row <= 5'h17 && cursor_col <= 7'h4F)
    else $error("cursor off screen");
  a_lock_local: assert property ($changed(alpha_lock) |->
    $past(alpha_key) || $past(alpha_key, 2))
    else $error("alpha lock changed without key");
  a_aux_source: assert property (aux_valid |->
    $past(rx_valid && rx_ready) && aux_data == $past(rx_data))
    else $error("aux word not the host character");
  a_prot_entry: assert property ($rose(protect_mode) |-> $past(tk && tc == 7'h26))
    else $error("protect mode set without its code");
  a_wprot_entry: assert property ($rose(write_protect) |-> $past(tk && tc == 7'h29))
    else $error("write protect set without its code");
  a_kb_disable: assert property ($fell(kb_enabled) |-> $past(tk && tc == 7'h23))
    else $error("keyboard disabled without its code");
endmodule // tei_core_sva

bind tei_core tei_core_sva sva_i (.core_clk, .nrst, .rx_valid, .rx_data, .rx_ready,
  .kb_valid, .kb_data, .kb_ready, .alpha_key, .aux_valid, .aux_data, .beep, .kb_enabled,
  .protect_mode, .write_protect, .alpha_lock, .cursor_row, .cursor_col);

// >>> testbench/tei_host.sv
// Host model that takes transmit words, stalling three cycles in four
module tei_host (
  input logic core_clk,
  input logic nrst,
  input logic tx_valid,
  input logic [6:0] tx_data,
  input logic tx_printer,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];
  logic [1:0] ph_reg;
  // Collect each word popped; ready only once per four cycles
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ph_reg <= 2'h0;
      tx_ready <= 1'b0;
    end
    else
    begin
      if (tx_valid && tx_ready)
        got.push_back({tx_printer, tx_data});
      ph_reg <= ph_reg + 2'h1;
      tx_ready <= (ph_reg == 2'h3);
    end
  end
endmodule // tei_host

// >>> testbench/terminal_escape_interpreter_bench.sv
// Self-checking bench for the escape-sequence interpreter
module terminal_escape_interpreter_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, nrst, rx_valid, rx_ready, kb_valid, kb_ready, alpha_key, screen_wipe_key;
  logic tx_valid, tx_printer, tx_ready, aux_valid, beep, kb_enabled, protect_mode;
  logic write_protect, alpha_lock, busy;
  logic [6:0] rx_data, kb_data, tx_data, aux_data, cursor_col;
  logic [4:0] cursor_row;
  logic [1:0] mode_sw;
  int error_cnt, num_checks, cyc;

  tei_core DUT (.core_clk, .nrst, .rx_valid, .rx_data, .rx_ready, .kb_valid, .kb_data,
    .kb_ready, .alpha_key, .screen_wipe_key, .mode_sw, .tx_valid, .tx_data, .tx_printer,
    .tx_ready, .aux_valid, .aux_data, .beep, .kb_enabled, .protect_mode, .write_protect,
    .alpha_lock, .cursor_row, .cursor_col, .busy);
  tei_host host (.core_clk, .nrst, .tx_valid, .tx_data, .tx_printer, .tx_ready);

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Cycle ceiling against hangs
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  // Offer one character on the host or keyboard side until taken
  task put(input bit kb, input logic [6:0] c);
    int n;
    n = 0;
    @(posedge core_clk);
    kb_data <= c;
    rx_data <= c;
    kb_valid <= kb;
    rx_valid <= !kb;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while ((kb ? kb_ready : rx_ready) !== 1'b1 && n < 4000);
    kb_valid <= 1'b0;
    rx_valid <= 1'b0;
    chk(n < 4000, "char not taken");
  endtask

  task idle();
    int n;
    n = 0;
    repeat (2) @(posedge core_clk);
    while (busy !== 1'b0 && n < 8000)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(n < 8000, "busy stuck");
    #1;
  endtask

  task hc(input logic [6:0] c);
    put(0, c);
    idle();
  endtask

  task kc(input logic [6:0] c);
    put(1, c);
    idle();
  endtask

  task esc(input logic [6:0] c);
    hc(7'h1B);
    hc(c);
  endtask

  task load(input logic [6:0] r, input logic [6:0] c);
    esc(7'h3D);
    hc(r);
    hc(c);
  endtask

  task pulse_alpha();
    @(posedge core_clk);
    alpha_key <= 1'b1;
    @(posedge core_clk);
    alpha_key <= 1'b0;
    idle();
  endtask

  // Bell gives a single-cycle beep
  task t_bell();
    put(0, 7'h07);
    #1 chk(beep === 1'b1, "no beep");
    @(posedge core_clk);
    #1 chk(beep === 1'b0, "beep stuck");
    idle();
  endtask

  // Address the last cell, then line feed at the bottom rolls
  task t_roll();
    load(7'h37, 7'h6F);
    chk(cursor_row === 5'h17 && cursor_col === 7'h4F, "load");
    hc(7'h0A);
    chk(cursor_row === 5'h17 && cursor_col === 7'h4F, "roll");
  endtask

  // Protected mode: home, wrap at bottom, down, new line, mode flags
  task t_prot();
    esc(7'h26);
    chk(protect_mode === 1'b1 && cursor_row === 5'h00 && cursor_col === 7'h00, "prot");
    load(7'h37, 7'h25);
    hc(7'h0A);
    chk(cursor_row === 5'h00 && cursor_col === 7'h05, "wrap");
    hc(7'h0A);
    chk(cursor_row === 5'h01 && cursor_col === 7'h05, "down");
    hc(7'h1F);
    chk(cursor_row === 5'h02 && cursor_col === 7'h00, "new line");
    esc(7'h27);
    chk(protect_mode === 1'b0, "unprot");
    esc(7'h29);
    chk(write_protect === 1'b1, "wp on");
    esc(7'h28);
    chk(write_protect === 1'b0, "wp off");
  endtask

  // Host disables keyboard; keyboard cannot enable; wipe key does
  task t_kbd();
    esc(7'h23);
    chk(kb_enabled === 1'b0, "kb off");
    kc(7'h1B);
    kc(7'h22);
    chk(kb_enabled === 1'b0, "kb self on");
    @(posedge core_clk);
    screen_wipe_key <= 1'b1;
    repeat (4) @(posedge core_clk);
    screen_wipe_key <= 1'b0;
    idle();
    chk(kb_enabled === 1'b1 && cursor_row === 5'h00 && cursor_col === 7'h00, "wipe");
  endtask

  // Keyboard escape in full duplex, block and half duplex mode
  task t_esc();
    @(posedge core_clk);
    mode_sw <= 2'h0;
    repeat (4) @(posedge core_clk);
    host.got.delete();
    kc(7'h1B);
    kc(7'h26);
    repeat (12) @(posedge core_clk);
    chk(host.got.size() == 2 && host.got[0] === 7'h1B && !protect_mode, "fdx");
    mode_sw <= 2'h2;
    repeat (4) @(posedge core_clk);
    host.got.delete();
    kc(7'h1B);
    kc(7'h26);
    chk(protect_mode === 1'b1 && host.got.size() == 0, "blk");
    @(posedge core_clk);
    mode_sw <= 2'h1;
    repeat (4) @(posedge core_clk);
    host.got.delete();
    kc(7'h1B);
    kc(7'h27);
    repeat (12) @(posedge core_clk);
    chk(host.got.size() == 2 && host.got[1] === 8'h27 && protect_mode === 1'b0, "hdx");
    mode_sw <= 2'h2;
    repeat (4) @(posedge core_clk);
  endtask

  // Alpha lock, typed text, then send-line returns the row up to cursor
  task t_send();
    pulse_alpha();
    chk(alpha_lock === 1'b1, "lock");
    kc(7'h61);
    hc(7'h42);
    kc(7'h31);
    host.got.delete();
    esc(7'h34);
    repeat (24) @(posedge core_clk);
    chk(host.got.size() == 4 && host.got[1] === 7'h42, "line");
    chk(host.got[0] === 7'h41 && host.got[2] === 7'h31, "case");
    chk(host.got[3] === 7'h0D, "cr");
    pulse_alpha();
    chk(alpha_lock === 1'b0, "unlock");
  endtask

  // Auxiliary forwarding on and off
  task t_aux();
    esc(7'h40);
    put(0, 7'h4B);
    #1 chk(aux_valid === 1'b1 && aux_data === 7'h4B, "aux");
    idle();
    esc(7'h41);
    put(0, 7'h4B);
    #1 chk(aux_valid === 1'b0, "aux off");
    idle();
  endtask

  // Block send from the host, then let the receiver drain
  task send(input logic [6:0] c);
    host.got.delete();
    esc(c);
    repeat (16) @(posedge core_clk);
  endtask

  // Protected fields seen through send-page, printer-send, tab and the erase codes
  task t_blk();
    esc(7'h29);
    hc(7'h58);
    hc(7'h58);
    esc(7'h28);
    hc(7'h5A);
    esc(7'h26);
    load(7'h21, 7'h2A);
    send(7'h35);
    chk(host.got.size() == 9 && host.got[5] === 8'h1C && host.got[6] === 8'h5A, "page");
    chk(host.got[7] === 8'h1F && host.got[8] === 8'h0D, "page end");
    send(7'h50);
    chk(host.got.size() == 14 && host.got[0] === 8'h8D && host.got[1] === 8'h8A, "print");
    chk(host.got[7] === 8'hD8 && host.got[10] === 8'h8D && host.got[13] === 8'h8A, "print end");
    load(7'h20, 7'h21);
    hc(7'h09);
    chk(cursor_row === 5'h00 && cursor_col === 7'h07, "tab");
    hc(7'h09);
    chk(cursor_row === 5'h00 && cursor_col === 7'h00, "tab home");
    load(7'h20, 7'h21);
    esc(7'h54);
    load(7'h21, 7'h20);
    send(7'h35);
    chk(host.got.size() == 5 && host.got[1] === 8'h1C && host.got[2] === 8'h5A, "erase line");
    esc(7'h2B);
    esc(7'h27);
    send(7'h35);
    chk(host.got.size() == 4 && host.got[0] === 8'h58 && host.got[2] === 8'h1F, "clear unprot");
    load(7'h20, 7'h26);
    esc(7'h59);
    load(7'h21, 7'h20);
    send(7'h35);
    chk(host.got.size() == 3 && host.got[0] === 8'h58 && host.got[1] === 8'h1F, "erase page");
  endtask

  // Main sequence
  initial
  begin
    {nrst, rx_valid, kb_valid, alpha_key, screen_wipe_key} = 5'h00;
    rx_data = 7'h00;
    kb_data = 7'h00;
    mode_sw = 2'h2;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    #1 chk(kb_enabled === 1'b1 && cursor_row === 5'h00 && cursor_col === 7'h00, "rst");
    esc(7'h2A);
    chk(protect_mode === 1'b0, "clear");
    t_bell();
    t_roll();
    t_prot();
    t_kbd();
    t_esc();
    t_send();
    t_aux();
    t_blk();
    stop_test();
  end
endmodule // terminal_escape_interpreter_bench
